/* File: hdl/dpm_decoder.sv */
`timescale 1ns/1ns
module dpm_decoder
(
   // Clock, reset and enable.
   input  wire logic              mclk,
   input  wire logic              reset,
   input  wire logic              clk_en,
   // Register port.
   input  wire logic [7:0]        reg_addr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output      logic [15:0]       reg_rdata,
   // Measured inputs in millivolts; the limit switches are single-bit logic levels.
   input  wire logic [15:0]       command_analog_input,
   input  wire logic [15:0]       reference_analog_input,
   input  wire logic [15:0]       stop_digital_input,
   input  wire logic              forward_limit_switch,
   input  wire logic              reverse_limit_switch,
   // Motor command.
   output      logic              motor_run,
   output      logic              motor_forward,
   output      logic [15:0]       motor_speed,
   output      logic [31:0]       motor_position,
   output      logic [1:0]        motor_law,
   output      logic              motor_emergency
);
   import dpm_pkg::*;

   // ****************************************************************
   // Configuration registers.
   // ****************************************************************
   logic [15:0] limit_trigger_polarity;
   logic [15:0] input_signal_polarity;
   logic [15:0] pot_usage_select;
   logic [15:0] stop_input_level_type;
   logic [15:0] pot_min_voltage;
   logic [15:0] pot_max_voltage;
   logic [15:0] switch_threshold_voltage;
   logic [15:0] midpoint_dead_zone;
   logic [15:0] command_source_type;
   logic [15:0] control_law_select;
   logic [31:0] total_stroke;
   logic [15:0] logic33_threshold;
   logic [15:0] logic5_threshold;
   logic [5:0]  status_bits;

   // Software writes; every register except status, speed and position is plain read-write.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         limit_trigger_polarity   <= RST_LIMIT_POL;
         input_signal_polarity    <= RST_INPUT_POL;
         pot_usage_select         <= RST_POT_USAGE;
         stop_input_level_type    <= RST_LEVEL_TYPE;
         pot_min_voltage          <= RST_POT_MIN;
         pot_max_voltage          <= RST_POT_MAX;
         switch_threshold_voltage <= RST_SW_THRESH;
         midpoint_dead_zone       <= RST_DEAD_ZONE;
         command_source_type      <= RST_CMD_SOURCE;
         control_law_select       <= RST_CTRL_LAW;
         total_stroke             <= RST_STROKE;
         logic33_threshold        <= RST_LVL33_THR;
         logic5_threshold         <= RST_LVL5_THR;
      end
      else if (clk_en && reg_wr)
      begin
         unique case (reg_addr)
            ADDR_LIMIT_POL:  limit_trigger_polarity   <= reg_wdata;
            ADDR_INPUT_POL:  input_signal_polarity    <= reg_wdata;
            ADDR_POT_USAGE:  pot_usage_select         <= reg_wdata;
            ADDR_LEVEL_TYPE: stop_input_level_type    <= reg_wdata;
            ADDR_POT_MIN:    pot_min_voltage          <= reg_wdata;
            ADDR_POT_MAX:    pot_max_voltage          <= reg_wdata;
            ADDR_SW_THRESH:  switch_threshold_voltage <= reg_wdata;
            ADDR_DEAD_ZONE:  midpoint_dead_zone       <= reg_wdata;
            ADDR_CMD_SOURCE: command_source_type      <= reg_wdata;
            ADDR_CTRL_LAW:   control_law_select       <= reg_wdata;
            ADDR_STROKE_LO:  total_stroke[15:0]       <= reg_wdata;
            ADDR_STROKE_HI:  total_stroke[31:16]      <= reg_wdata;
            ADDR_LVL33_THR:  logic33_threshold        <= reg_wdata;
            ADDR_LVL5_THR:   logic5_threshold         <= reg_wdata;
            default:         ;
         endcase
      end
   end

   // Read data stands for the one cycle after the strobe; unmapped reads give zero.
   always_ff @(posedge mclk)
   begin
      if (reset || (clk_en && !reg_rd))
         reg_rdata <= 16'h0000;
      else if (clk_en)
      begin
         unique case (reg_addr)
            ADDR_LIMIT_POL:  reg_rdata <= limit_trigger_polarity;
            ADDR_INPUT_POL:  reg_rdata <= input_signal_polarity;
            ADDR_POT_USAGE:  reg_rdata <= pot_usage_select;
            ADDR_LEVEL_TYPE: reg_rdata <= stop_input_level_type;
            ADDR_POT_MIN:    reg_rdata <= pot_min_voltage;
            ADDR_POT_MAX:    reg_rdata <= pot_max_voltage;
            ADDR_SW_THRESH:  reg_rdata <= switch_threshold_voltage;
            ADDR_DEAD_ZONE:  reg_rdata <= midpoint_dead_zone;
            ADDR_CMD_SOURCE: reg_rdata <= command_source_type;
            ADDR_CTRL_LAW:   reg_rdata <= control_law_select;
            ADDR_STROKE_LO:  reg_rdata <= total_stroke[15:0];
            ADDR_STROKE_HI:  reg_rdata <= total_stroke[31:16];
            ADDR_LVL33_THR:  reg_rdata <= logic33_threshold;
            ADDR_LVL5_THR:   reg_rdata <= logic5_threshold;
            ADDR_STATUS:     reg_rdata <= {10'h000, status_bits};
            ADDR_SPEED:      reg_rdata <= motor_speed;
            ADDR_POS_LO:     reg_rdata <= motor_position[15:0];
            ADDR_POS_HI:     reg_rdata <= motor_position[31:16];
            default:         reg_rdata <= 16'h0000;
         endcase
      end
   end

   // ****************************************************************
   // Stop and limit inputs.
   // ****************************************************************
   logic [15:0] stop_threshold;
   logic        stop_level;
   logic        stop_level_d;
   logic        fwd_lim_d;
   logic        rev_lim_d;
   logic        stop_active;
   logic        stop_edge_latch;
   logic        fwd_block;
   logic        rev_block;

   // The threshold depends on how the stop input is wired.
   always_comb
   begin
      unique case (stop_input_level_type)
         LVL_3V3: stop_threshold = logic33_threshold;
         LVL_5V:  stop_threshold = logic5_threshold;
         default: stop_threshold = switch_threshold_voltage;
      endcase
   end
   assign stop_level = (stop_digital_input >= stop_threshold);

   // Previous samples feed the edge detectors.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         stop_level_d <= 1'b1;
         fwd_lim_d    <= 1'b1;
         rev_lim_d    <= 1'b1;
      end
      else if (clk_en)
      begin
         stop_level_d <= stop_level;
         fwd_lim_d    <= forward_limit_switch;
         rev_lim_d    <= reverse_limit_switch;
      end
   end

   // An edge-triggered stop toggles a latch, so one press stops and the next resumes.
   always_ff @(posedge mclk)
   begin
      if (reset)
         stop_edge_latch <= 1'b0;
      else if (clk_en)
      begin
         if ((input_signal_polarity == POL_FALL && stop_level_d && !stop_level) ||
             (input_signal_polarity == POL_RISE && !stop_level_d && stop_level))
            stop_edge_latch <= !stop_edge_latch;
      end
   end

   // Stop polarity decode.
   always_comb
   begin
      unique case (input_signal_polarity)
         POL_LOW:  stop_active = !stop_level;
         POL_HIGH: stop_active = stop_level;
         default:  stop_active = stop_edge_latch;
      endcase
   end

   // Limit decoding; edge modes hold the block until the opposite level returns.
   function automatic logic limit_hit(input logic [15:0] pol, input logic now, input logic prev);
      logic hit;
      unique case (pol)
         POL_LOW:  hit = !now;
         POL_HIGH: hit = now;
         POL_FALL: hit = !now && !prev;
         POL_RISE: hit = now && prev;
         default:  hit = 1'b0;
      endcase
      return hit;
   endfunction
   assign fwd_block = limit_hit(limit_trigger_polarity, forward_limit_switch, fwd_lim_d);
   assign rev_block = limit_hit(limit_trigger_polarity, reverse_limit_switch, rev_lim_d);
   // ****************************************************************
   // Mode selection and pot arithmetic.
   // ****************************************************************
   dpm_mode_t   mode;
   logic [15:0] cmd_clip;
   logic [15:0] ref_clip;
   logic [15:0] diff_mag;
   logic        cmd_above;
   logic [16:0] span;
   logic [31:0] next_speed;
   logic [31:0] next_offset;
   logic [15:0] half_span;

   // Only pot source with coordinated usage drives the motor.
   always_comb
   begin
      if (command_source_type != SRC_POT || pot_usage_select != USAGE_COORD)
         mode = DPM_IDLE;
      else if (control_law_select == LAW_POSITION)
         mode = DPM_POS;
      else if (control_law_select >= LAW_DUTY && control_law_select <= LAW_SPEED_LOOP)
         mode = DPM_SPEED;
      else
         mode = DPM_IDLE;
   end

   // Readings are clamped to the calibrated span before use.
   always_comb
   begin
      cmd_clip = command_analog_input;
      if (cmd_clip < pot_min_voltage)
         cmd_clip = pot_min_voltage;
      if (cmd_clip > pot_max_voltage)
         cmd_clip = pot_max_voltage;
      ref_clip = reference_analog_input;
      if (ref_clip < pot_min_voltage)
         ref_clip = pot_min_voltage;
      if (ref_clip > pot_max_voltage)
         ref_clip = pot_max_voltage;
   end

   // Magnitude and sign of the difference.
   assign cmd_above = (cmd_clip > ref_clip);
   assign diff_mag  = cmd_above ? (cmd_clip - ref_clip) : (ref_clip - cmd_clip);

   // Linear scaling; the divider is big but the pots move slowly at this clock.
   always_comb
   begin
      span      = {1'b0, pot_max_voltage} - {1'b0, pot_min_voltage};
      half_span = cmd_above ? (pot_max_voltage - ref_clip) : (ref_clip - pot_min_voltage);
      if (span == 17'h00000)
         next_speed = 32'h00000000;
      else
         next_speed = ({16'h0000, diff_mag} * {16'h0000, SPEED_FULL}) / {15'h0000, span};
      if (half_span == 16'h0000)
         next_offset = 32'h00000000;
      else
         next_offset = 32'((64'(diff_mag) * 64'(total_stroke[31:1])) / 64'(half_span));
   end

   // ****************************************************************
   // Motor command outputs.
   // ****************************************************************
   logic in_dead_zone;
   assign in_dead_zone = (diff_mag <= midpoint_dead_zone);
   // Speed mode stops on stop, dead zone or a limit in the running direction.
   // Position mode aims at midpoint plus or minus the scaled offset.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         motor_run       <= 1'b0;
         motor_forward   <= 1'b0;
         motor_speed     <= 16'h0000;
         motor_position  <= 32'h00000000;
         motor_law       <= 2'b00;
         motor_emergency <= 1'b0;
      end
      else if (clk_en)
      begin
         motor_emergency <= stop_active && (mode != DPM_IDLE);
         motor_law       <= control_law_select[1:0];
         unique case (mode)
            DPM_SPEED:
            begin
               motor_forward <= cmd_above;
               if (stop_active || in_dead_zone ||
                   (cmd_above && fwd_block) || (!cmd_above && rev_block))
               begin
                  motor_run   <= 1'b0;
                  motor_speed <= 16'h0000;
               end
               else
               begin
                  motor_run   <= 1'b1;
                  motor_speed <= next_speed[15:0];
               end
            end
            DPM_POS:
            begin
               motor_run <= !stop_active;
               if (stop_active)
                  motor_speed <= 16'h0000;
               else if (in_dead_zone)
                  motor_position <= {1'b0, total_stroke[31:1]};
               else if (cmd_above && !fwd_block)
               begin
                  motor_forward  <= 1'b1;
                  motor_position <= {1'b0, total_stroke[31:1]} + next_offset;
               end
               else if (!cmd_above && !rev_block)
               begin
                  motor_forward  <= 1'b0;
                  motor_position <= {1'b0, total_stroke[31:1]} - next_offset;
               end
            end
            DPM_IDLE:
            begin
               motor_run   <= 1'b0;
               motor_speed <= 16'h0000;
            end
         endcase
      end
   end

   // Status snapshot for software.
   always_ff @(posedge mclk)
   begin
      if (reset)
         status_bits <= 6'h00;
      else if (clk_en)
      begin
         status_bits[ST_RUN]  <= motor_run;
         status_bits[ST_FWD]  <= motor_forward;
         status_bits[ST_STOP] <= stop_active;
         status_bits[ST_LIMF] <= fwd_block;
         status_bits[ST_LIMR] <= rev_block;
         status_bits[ST_POS]  <= (mode == DPM_POS);
      end
   end

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   property p_stop_halts;
      @(posedge mclk) disable iff (reset)
      clk_en && stop_active && mode == DPM_SPEED |=> !motor_run && motor_speed == 16'h0000;
   endproperty
   a_stop_halts: assert property (p_stop_halts) else $error("stop did not halt");
   property p_direction;
      @(posedge mclk) disable iff (reset)
      clk_en && mode == DPM_SPEED |=> motor_forward == $past(cmd_above);
   endproperty
   a_direction: assert property (p_direction) else $error("wrong direction");
   property p_dead_zone;
      @(posedge mclk) disable iff (reset)
      clk_en && mode == DPM_SPEED && in_dead_zone |=> !motor_run;
   endproperty
   a_dead_zone: assert property (p_dead_zone) else $error("ran in dead zone");
   property p_idle;
      @(posedge mclk) disable iff (reset)
      clk_en && command_source_type != SRC_POT |=> !motor_run;
   endproperty
   a_idle: assert property (p_idle) else $error("ran without pot source");
   property p_limit_fwd;
      @(posedge mclk) disable iff (reset)
      clk_en && mode == DPM_SPEED && cmd_above && fwd_block |=> !motor_run;
   endproperty
   a_limit_fwd: assert property (p_limit_fwd) else $error("forward limit ignored");
   property p_limit_off;
      @(posedge mclk) disable iff (reset)
      limit_trigger_polarity == POL_DISABLE |-> !fwd_block && !rev_block;
   endproperty
   a_limit_off: assert property (p_limit_off) else $error("disabled limit acted");
   property p_emergency;
      @(posedge mclk) disable iff (reset)
      clk_en && mode == DPM_POS && stop_active |=> motor_emergency && !motor_run;
   endproperty
   a_emergency: assert property (p_emergency) else $error("no emergency stop");
   property p_pos_up;
      @(posedge mclk) disable iff (reset)
      clk_en && mode == DPM_POS && !stop_active && !in_dead_zone && cmd_above && !fwd_block
      |=> motor_position >= {1'b0, $past(total_stroke[31:1])};
   endproperty
   a_pos_up: assert property (p_pos_up) else $error("position below midpoint");
   property p_pos_down;
      @(posedge mclk) disable iff (reset)
      clk_en && mode == DPM_POS && !stop_active && !in_dead_zone && !cmd_above && !rev_block
      |=> motor_position <= {1'b0, $past(total_stroke[31:1])};
   endproperty
   a_pos_down: assert property (p_pos_down) else $error("position above midpoint");
   c_speed_run: cover property (@(posedge mclk) mode == DPM_SPEED && motor_run);
   c_reverse:   cover property (@(posedge mclk) motor_run && !motor_forward);
   c_pos_mode:  cover property (@(posedge mclk) mode == DPM_POS && motor_run);
   c_estop:     cover property (@(posedge mclk) motor_emergency);
endmodule

/* File: hdl/dpm_pkg.sv */
package dpm_pkg;
   // ****************************************************************
   // Register offsets.
   // ****************************************************************
   localparam logic [7:0] ADDR_LIMIT_POL   = 8'h80;
   localparam logic [7:0] ADDR_INPUT_POL   = 8'h81;
   localparam logic [7:0] ADDR_POT_USAGE   = 8'h82;
   localparam logic [7:0] ADDR_LEVEL_TYPE  = 8'h85;
   localparam logic [7:0] ADDR_POT_MIN     = 8'h86;
   localparam logic [7:0] ADDR_POT_MAX     = 8'h87;
   localparam logic [7:0] ADDR_SW_THRESH   = 8'h8a;
   localparam logic [7:0] ADDR_DEAD_ZONE   = 8'h8b;
   localparam logic [7:0] ADDR_CMD_SOURCE  = 8'h9a;
   localparam logic [7:0] ADDR_CTRL_LAW    = 8'h9b;
   localparam logic [7:0] ADDR_STROKE_LO   = 8'ha2;
   localparam logic [7:0] ADDR_STROKE_HI   = 8'ha3;
   localparam logic [7:0] ADDR_LVL33_THR   = 8'hc0;
   localparam logic [7:0] ADDR_LVL5_THR    = 8'hc1;
   localparam logic [7:0] ADDR_STATUS      = 8'hc2;
   localparam logic [7:0] ADDR_SPEED       = 8'hc3;
   localparam logic [7:0] ADDR_POS_LO      = 8'hc4;
   localparam logic [7:0] ADDR_POS_HI      = 8'hc5;
   // ****************************************************************
   // Reset values.
   // ****************************************************************
   localparam logic [15:0] RST_LIMIT_POL   = 16'h0000;
   localparam logic [15:0] RST_INPUT_POL   = 16'h0000;
   localparam logic [15:0] RST_POT_USAGE   = 16'h0002;
   localparam logic [15:0] RST_LEVEL_TYPE  = 16'h0000;
   localparam logic [15:0] RST_POT_MIN     = 16'h0000;
   localparam logic [15:0] RST_POT_MAX     = 16'h0cda;
   localparam logic [15:0] RST_SW_THRESH   = 16'h07d0;
   localparam logic [15:0] RST_DEAD_ZONE   = 16'h0000;
   localparam logic [15:0] RST_CMD_SOURCE  = 16'h0001;
   localparam logic [15:0] RST_CTRL_LAW    = 16'h0001;
   localparam logic [31:0] RST_STROKE      = 32'h00010000;
   localparam logic [15:0] RST_LVL33_THR   = 16'h0672;
   localparam logic [15:0] RST_LVL5_THR    = 16'h09c4;
   // ****************************************************************
   // Setting codes.
   // ****************************************************************
   localparam logic [15:0] POL_LOW         = 16'h0000;
   localparam logic [15:0] POL_HIGH        = 16'h0001;
   localparam logic [15:0] POL_FALL        = 16'h0002;
   localparam logic [15:0] POL_RISE        = 16'h0003;
   localparam logic [15:0] POL_DISABLE     = 16'h0004;
   localparam logic [15:0] USAGE_COORD     = 16'h0002;
   localparam logic [15:0] LVL_CONTACT     = 16'h0000;
   localparam logic [15:0] LVL_3V3         = 16'h0001;
   localparam logic [15:0] LVL_5V          = 16'h0002;
   localparam logic [15:0] SRC_POT         = 16'h0001;
   localparam logic [15:0] LAW_DUTY        = 16'h0001;
   localparam logic [15:0] LAW_SPEED_LOOP  = 16'h0003;
   localparam logic [15:0] LAW_POSITION    = 16'h0004;
   // Status bit positions.
   localparam int ST_RUN  = 0;
   localparam int ST_FWD  = 1;
   localparam int ST_STOP = 2;
   localparam int ST_LIMF = 3;
   localparam int ST_LIMR = 4;
   localparam int ST_POS  = 5;
   // Full-scale speed command.
   localparam logic [15:0] SPEED_FULL      = 16'hffff;
   // Decoder modes, one-hot.
   typedef enum logic [2:0]
   {
      DPM_IDLE  = 3'b001,
      DPM_SPEED = 3'b010,
      DPM_POS   = 3'b100
   } dpm_mode_t;
endpackage

/* File: verif/dpm_pot_model.sv */
`timescale 1ns/1ns
// Far side: two pots, the stop contact and both limit contacts, settling on the clock edge.
module dpm_pot_model
(
   // Clock.
   input  wire logic        mclk,
   // Levels the bench asks for.
   input  wire logic [15:0] set_cmd,
   input  wire logic [15:0] set_ref,
   input  wire logic [15:0] set_stop,
   input  wire logic        set_limf,
   input  wire logic        set_limr,
   // Levels seen at the block.
   output logic      [15:0] cmd_mv,
   output logic      [15:0] ref_mv,
   output logic      [15:0] stop_mv,
   output logic             limf,
   output logic             limr
);
   // A pot wiper moves between samples, never within one, so levels change only on the edge.
   always_ff @(posedge mclk)
   begin
      cmd_mv  <= set_cmd;
      ref_mv  <= set_ref;
      stop_mv <= set_stop;
      limf    <= set_limf;
      limr    <= set_limr;
   end
endmodule

/* File: verif/dual_pot_motor_command_decoder_tb_top.sv */
`timescale 1ns/1ns
module dual_pot_motor_command_decoder_tb_top;
   import dpm_pkg::*;
   logic        mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0, lf = 1, lr = 1, en = 1;
   logic [7:0]  reg_addr = '0;
   logic [15:0] reg_wdata = '0, c = '0, r = '0, s = 16'h0bb8, reg_rdata, speed;
   logic [15:0] cmv, rmv, smv;
   logic [31:0] pos;
   logic        limf, limr, run, fwd, emg;
   logic [1:0]  law;
   int          fail_count = 0, checks_done = 0;
   // The clock runs at 10 MHz.
   always #50 mclk = ~mclk;
   dpm_pot_model i_pot (.mclk(mclk), .set_cmd(c), .set_ref(r), .set_stop(s), .set_limf(lf),
      .set_limr(lr), .cmd_mv(cmv), .ref_mv(rmv), .stop_mv(smv), .limf(limf), .limr(limr));
   dpm_decoder i_dut (.mclk(mclk), .reset(reset), .clk_en(en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .command_analog_input(cmv), .reference_analog_input(rmv), .stop_digital_input(smv),
      .forward_limit_switch(limf), .reverse_limit_switch(limr), .motor_run(run),
      .motor_forward(fwd), .motor_speed(speed), .motor_position(pos), .motor_law(law),
      .motor_emergency(emg));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1;
      @(posedge mclk);
      reg_wr <= 0;
   endtask
   // Read data stand only in the cycle after the strobe, so they are sampled there.
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge mclk);
      reg_rd <= 0;
      #1 chk("reg_rdata", {16'h0, e}, {16'h0, reg_rdata});
   endtask
   // Inputs pass the model and the decoder, so four edges leave ample settling.
   task automatic drv(input logic [15:0] cc, rr, ss, input logic ff, fr);
      @(posedge mclk);
      {c, r, s, lf, lr} <= {cc, rr, ss, ff, fr};
      repeat (4) @(posedge mclk);
      #1;
   endtask
   task automatic mot(input logic er, ef);
      chk("motor_run", {31'h0, er}, {31'h0, run});
      chk("motor_forward", {31'h0, ef}, {31'h0, fwd});
   endtask
   task automatic t_regs;
      rd(8'h80, 16'h0000);
      rd(8'h81, 16'h0000);
      rd(8'h85, 16'h0000);
      rd(8'h86, 16'h0000);
      rd(8'h87, 16'h0cda);
      rd(8'h8a, 16'h07d0);
      rd(8'h8b, 16'h0000);
      rd(8'h8c, 16'h0000);
      wr(8'h8b, 16'h0064);
      rd(8'h8b, 16'h0064);
      wr(8'h8b, 16'h0000);
   endtask
   task automatic t_speed;
      drv(16'd2000, 16'd1000, 16'd3000, 1, 1);
      mot(1, 1);
      chk("motor_speed", (32'd1000 * 32'hffff) / 32'd3290, {16'h0, speed});
      rd(8'hc3, 16'd19919);
      drv(16'd1000, 16'd2000, 16'd3000, 1, 1);
      mot(1, 0);
      rd(8'hc2, 16'h0001);
      drv(16'd1000, 16'd2000, 16'd0, 1, 1);
      chk("motor_run", 0, {31'h0, run});
      wr(8'h81, POL_HIGH);
      drv(16'd2000, 16'd1000, 16'd0, 1, 1);
      mot(1, 1);
      drv(16'd2000, 16'd1000, 16'd3000, 1, 1);
      chk("motor_run", 0, {31'h0, run});
      wr(8'h81, POL_FALL);
      drv(16'd2000, 16'd1000, 16'd0, 1, 1);
      chk("motor_run", 0, {31'h0, run});
      drv(16'd2000, 16'd1000, 16'd3000, 1, 1);
      drv(16'd2000, 16'd1000, 16'd0, 1, 1);
      chk("motor_run", 1, {31'h0, run});
      wr(8'h81, POL_LOW);
      wr(8'h85, LVL_3V3);
      drv(16'd2000, 16'd1000, 16'd1800, 1, 1);
      chk("motor_run", 1, {31'h0, run});
      wr(8'h85, LVL_5V);
      drv(16'd2000, 16'd1000, 16'd2200, 1, 1);
      chk("motor_run", 0, {31'h0, run});
      wr(8'h85, LVL_CONTACT);
      wr(8'h8b, 16'h0064);
      drv(16'd1050, 16'd1000, 16'd3000, 1, 1);
      chk("motor_run", 0, {31'h0, run});
      wr(8'h8b, 16'h0000);
      for (int p = 0; p < 5; p++)
      begin
         wr(8'h80, p[15:0]);
         drv(16'd2000, 16'd1000, 16'd3000, p % 2 == 0, 1);
         drv(16'd2000, 16'd1000, 16'd3000, p % 2 == 1, 1);
         chk("motor_run", {31'h0, p == 4}, {31'h0, run});
      end
      wr(8'h80, POL_LOW);
      drv(16'd1000, 16'd2000, 16'd3000, 1, 0);
      mot(0, 0);
      drv(16'd2000, 16'd1000, 16'd3000, 1, 0);
      mot(1, 1);
      wr(8'h80, POL_DISABLE);
      wr(8'h9b, 16'h0002);
      drv(16'd2000, 16'd1000, 16'd3000, 1, 1);
      chk("motor_law", 2, {30'h0, law});
      wr(8'h9b, LAW_SPEED_LOOP);
      drv(16'd2000, 16'd1000, 16'd3000, 1, 1);
      chk("motor_law", 3, {30'h0, law});
      mot(1, 1);
   endtask
   task automatic t_pos;
      wr(8'h9b, LAW_POSITION);
      drv(16'd1000, 16'd1000, 16'd3000, 1, 1);
      chk("motor_position", RST_STROKE / 2, pos);
      drv(16'd3290, 16'd1000, 16'd3000, 1, 1);
      chk("motor_position", RST_STROKE, pos);
      drv(16'd0, 16'd1000, 16'd3000, 1, 1);
      chk("motor_position", 0, pos);
      drv(16'd0, 16'd1000, 16'd0, 1, 1);
      chk("motor_emergency", 1, {31'h0, emg});
      // With the enable low the released stop must not reach the outputs.
      @(posedge mclk);
      en <= 0;
      drv(16'd2000, 16'd1000, 16'd3000, 1, 1);
      chk("motor_emergency", 1, {31'h0, emg});
      @(posedge mclk);
      en <= 1;
      drv(16'd2000, 16'd1000, 16'd3000, 1, 1);
      mot(1, 1);
      wr(8'h9a, 16'h0000);
      drv(16'd2000, 16'd1000, 16'd3000, 1, 1);
      chk("motor_run", 0, {31'h0, run});
      wr(8'h9a, SRC_POT);
      wr(8'h82, 16'h0001);
      drv(16'd2000, 16'd1000, 16'd3000, 1, 1);
      chk("motor_run", 0, {31'h0, run});
   endtask
   // A hung run is cut short and counted as a mismatch.
   initial
   begin
      #5000000 fail_count++;
      tally_and_finish();
   end
   initial
   begin
      repeat (5) @(posedge mclk);
      reset <= 0;
      t_regs();
      t_speed();
      t_pos();
      tally_and_finish();
   end
endmodule
